/* hdl/host_endpoint_defines.vh */
`ifndef HOST_ENDPOINT_DEFINES_VH
`define HOST_ENDPOINT_DEFINES_VH
`define CTRL_DOWN_W      31
`define CTRL_UP_W        17
`define ADDR_W           8
`define WORD_W           16
`define WIRE_IN_BASE     8'h00
`define WIRE_IN_LAST     8'h1F
`define WIRE_OUT_BASE    8'h20
`define WIRE_OUT_LAST    8'h3F
`define OP_IDLE          3'h0
`define OP_WRITE         3'h1
`define OP_COMMIT        3'h2
`define OP_CAPTURE       3'h3
`define OP_READ          3'h4
`define DN_CLK_BIT       0
`define DN_OP_LO         1
`define DN_OP_HI         3
`define DN_ADDR_LO       4
`define DN_ADDR_HI       11
`define DN_DATA_LO       12
`define DN_DATA_HI       27
`define UP_VALID_BIT     16
`endif

/* hdl/host_endpoint_bus_wires.v */
// Operation
// - The gateway meets the microcontroller with 8 input, 2 output and 16 bidirectional pins.
// - The gateway drives a 31-bit control bundle to every endpoint.
// - The gateway takes a 17-bit return bundle from the endpoints.
// - The gateway outputs a bus clock at half the clk_sys rate that also rides inside the control bundle.
// - Every endpoint attaches to all 48 shared bus lines.
// - Each endpoint takes its address from a constant 8-bit input port.
// - A wire input presents a 16-bit level word to user logic.
// - Wire input values are staged first and then all updated on one clock edge.
// - A wire output accepts a 16-bit word from user logic, read on each refresh.
// - On refresh all wire outputs are sampled on one edge and then read one by one.
// - The bus address selects which endpoint takes part in a write or read; commit and capture act on every endpoint.
`timescale 1ns/1ps
`include "host_endpoint_defines.vh"

// Host pin usage: in[0] strobe, in[3:1] op, in[4] address phase; out[0] read valid, out[1] one-cycle read-done pulse.
module host_gateway
(
   // System
   input  wire                      clk_sys,
   input  wire                      rst_n,
   // Host pins
   input  wire [7:0]                host_pin_inputs,
   output reg  [1:0]                host_pin_outputs,
   input  wire [15:0]               host_pin_bidir_data_in,
   output reg  [15:0]               host_pin_bidir_data_out,
   output reg                       host_pin_bidir_data_oe,
   // Target bus
   output reg                       target_bus_clock,
   output wire [`CTRL_DOWN_W-1:0]   target_ctrl_down,
   input  wire [`CTRL_UP_W-1:0]     target_ctrl_up
);
   reg  [7:0]   in_s1;
   reg  [7:0]   in_s2;
   reg  [15:0]  dat_s1;
   reg  [15:0]  dat_s2;
   reg          strobe_d;
   reg  [7:0]   addr;
   reg  [2:0]   op;
   reg  [15:0]  data;
   reg          rd_wait;
   wire         strobe_rise;
   wire         strobe_fall;

   assign strobe_rise = in_s2[0] & ~strobe_d;
   // The host takes the data pins back once its strobe ends, so the read drive is released then.
   assign strobe_fall = ~in_s2[0] & strobe_d;
   // Bus clock rides in bit 0 of the control bundle.
   assign target_ctrl_down = {3'h0, data, addr, op, target_bus_clock};

   // Host pins pass two flip-flops before use.
   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_s1    <= 8'h00;
         in_s2    <= 8'h00;
         dat_s1   <= 16'h0000;
         dat_s2   <= 16'h0000;
         strobe_d <= 1'b0;
      end
      else
      begin
         in_s1    <= host_pin_inputs;
         in_s2    <= in_s1;
         dat_s1   <= host_pin_bidir_data_in;
         dat_s2   <= dat_s1;
         strobe_d <= in_s2[0];
      end
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         target_bus_clock        <= 1'b0;
         addr                    <= 8'h00;
         op                      <= `OP_IDLE;
         data                    <= 16'h0000;
         rd_wait                 <= 1'b0;
         host_pin_outputs        <= 2'h0;
         host_pin_bidir_data_out <= 16'h0000;
         host_pin_bidir_data_oe  <= 1'b0;
      end
      else
      begin
         target_bus_clock <= ~target_bus_clock;
         op               <= `OP_IDLE;
         rd_wait          <= 1'b0;
         host_pin_outputs[1] <= rd_wait;
         if (strobe_rise)
         begin
            if (in_s2[4])
               addr <= dat_s2[7:0];
            else
            begin
               op   <= in_s2[3:1];
               data <= dat_s2;
               if (in_s2[3:1] == `OP_READ)
                  rd_wait <= 1'b1;
            end
            host_pin_bidir_data_oe <= 1'b0;
            host_pin_outputs[0]    <= 1'b0;
         end
         if (strobe_fall)
         begin
            host_pin_bidir_data_oe <= 1'b0;
            host_pin_outputs[0]    <= 1'b0;
         end
         if (rd_wait)
         begin
            host_pin_bidir_data_out <= target_ctrl_up[15:0];
            host_pin_bidir_data_oe  <= 1'b1;
            host_pin_outputs[0]     <= target_ctrl_up[`UP_VALID_BIT];
         end
      end
   end
endmodule // host_gateway

module wire_input_endpoint
(
   // Target bus
   input  wire                      clk_sys,
   input  wire                      rst_n,
   input  wire [`CTRL_DOWN_W-1:0]   target_ctrl_down,
   output wire [`CTRL_UP_W-1:0]     target_ctrl_up,
   // Configuration and user side
   input  wire [`ADDR_W-1:0]        endpoint_select_code,
   output reg  [`WORD_W-1:0]        wire_value_to_user
);
   reg  [`WORD_W-1:0] staged;
   wire               hit;

   assign hit = target_ctrl_down[`DN_ADDR_HI:`DN_ADDR_LO] == endpoint_select_code;
   assign target_ctrl_up = {`CTRL_UP_W{1'b0}};

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         staged             <= 16'h0000;
         wire_value_to_user <= 16'h0000;
      end
      else
      begin
         if (hit && target_ctrl_down[`DN_OP_HI:`DN_OP_LO] == `OP_WRITE)
            staged <= target_ctrl_down[`DN_DATA_HI:`DN_DATA_LO];
         if (target_ctrl_down[`DN_OP_HI:`DN_OP_LO] == `OP_COMMIT)
            wire_value_to_user <= staged;
      end
   end
endmodule // wire_input_endpoint

module wire_output_endpoint
(
   // Target bus
   input  wire                      clk_sys,
   input  wire                      rst_n,
   input  wire [`CTRL_DOWN_W-1:0]   target_ctrl_down,
   output wire [`CTRL_UP_W-1:0]     target_ctrl_up,
   // Configuration and user side
   input  wire [`ADDR_W-1:0]        endpoint_select_code,
   input  wire [`WORD_W-1:0]        wire_value_from_user
);
   reg  [`WORD_W-1:0] held;
   wire               hit;

   assign hit = target_ctrl_down[`DN_ADDR_HI:`DN_ADDR_LO] == endpoint_select_code;
   assign target_ctrl_up = hit ? {1'b1, held} : {`CTRL_UP_W{1'b0}};

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         held <= 16'h0000;
      else if (target_ctrl_down[`DN_OP_HI:`DN_OP_LO] == `OP_CAPTURE)
         held <= wire_value_from_user;
   end
endmodule // wire_output_endpoint

/* bench/host_mcu.sv */
`timescale 1ns/1ps
module host_mcu
(
   // Host pins
   input  wire        clk_sys,
   output reg  [7:0]  pins = 8'h00,
   output reg  [15:0] data = 16'h0000
);
   // One strobe of 400 ns; data is inverted once the strobe ends.
   task step(input [3:0] ctl, input [15:0] d);
      begin
         @(posedge clk_sys) #5 pins = {3'h0, ctl, 1'b0};
         data = d;
         repeat (4) @(posedge clk_sys);
         #5 pins[0] = 1'b1;
         repeat (4) @(posedge clk_sys);
         #5 pins[0] = 1'b0;
         data = ~d;
      end
   endtask
endmodule // host_mcu

/* bench/host_gateway_asserts.sv */
`timescale 1ns/1ps
module host_gateway_asserts
(
   // Watched ports
   input wire        clk_sys,
   input wire        rst_n,
   input wire [7:0]  host_pin_inputs,
   input wire [1:0]  host_pin_outputs,
   input wire        host_pin_bidir_data_oe,
   input wire        target_bus_clock,
   input wire [30:0] target_ctrl_down
);
   wire [2:0] op = target_ctrl_down[3:1];
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_strobe(c);
      $rose(host_pin_inputs[0]) && host_pin_inputs[4:1] == c;
   endsequence
   a_clk_toggle: assert property (1 |=> target_bus_clock != $past(target_bus_clock))
      else $error("bus clock stuck");
   a_clk_bundle: assert property (target_ctrl_down[0] == target_bus_clock)
      else $error("bundle clock");
   a_down_pad: assert property (target_ctrl_down[30:28] == 3'h0)
      else $error("bundle pad");
   a_op_pulse: assert property (op != 3'h0 |=> op == 3'h0)
      else $error("op too long");
   a_addr_steady: assert property (op != 3'h0 |-> $stable(target_ctrl_down[11:4]))
      else $error("address moved");
   a_commit_sent: assert property (s_strobe(4'h2) |-> ##[1:6] op == 3'h2)
      else $error("no commit");
   a_read_drive: assert property (s_strobe(4'h4) |-> ##[1:6] host_pin_bidir_data_oe)
      else $error("no read drive");
   a_valid_oe: assert property (host_pin_outputs[0] |-> host_pin_bidir_data_oe)
      else $error("valid undriven");
endmodule // host_gateway_asserts

/* bench/host_endpoint_bus_wires_tb.sv */
`timescale 1ns/1ps
module host_endpoint_bus_wires_tb;
   reg         clk_sys = 1'b0;
   reg         rst_n = 1'b0;
   reg  [15:0] ua = 16'h1234;
   wire [7:0]  pins;
   wire [15:0] md, din, dout, wa, wb;
   wire [1:0]  hout;
   wire        oe;
   wire [30:0] dn;
   wire [16:0] u0, u1, u2, u3;
   integer     fail_count = 0;
   integer     comparisons = 0;
   integer     i;
   reg  [24:0] rows [0:3];
   always #50 clk_sys = ~clk_sys;
   assign din = oe ? dout : md;
   host_mcu u_host_mcu (.clk_sys(clk_sys), .pins(pins), .data(md));
   host_gateway u_host_gateway (.clk_sys(clk_sys), .rst_n(rst_n), .host_pin_inputs(pins),
      .host_pin_outputs(hout), .host_pin_bidir_data_in(din), .host_pin_bidir_data_out(dout),
      .host_pin_bidir_data_oe(oe), .target_bus_clock(), .target_ctrl_down(dn),
      .target_ctrl_up(u0 | u1 | u2 | u3));
   wire_input_endpoint u_wire_input_endpoint_a (.clk_sys(clk_sys), .rst_n(rst_n),
      .target_ctrl_down(dn), .target_ctrl_up(u0), .endpoint_select_code(8'h00),
      .wire_value_to_user(wa));
   wire_input_endpoint u_wire_input_endpoint_b (.clk_sys(clk_sys), .rst_n(rst_n),
      .target_ctrl_down(dn), .target_ctrl_up(u1), .endpoint_select_code(8'h1F),
      .wire_value_to_user(wb));
   wire_output_endpoint u_wire_output_endpoint_a (.clk_sys(clk_sys), .rst_n(rst_n),
      .target_ctrl_down(dn), .target_ctrl_up(u2), .endpoint_select_code(8'h20),
      .wire_value_from_user(ua));
   wire_output_endpoint u_wire_output_endpoint_b (.clk_sys(clk_sys), .rst_n(rst_n),
      .target_ctrl_down(dn), .target_ctrl_up(u3), .endpoint_select_code(8'h3F),
      .wire_value_from_user(16'hABCD));
   task check(input [16:0] got, input [16:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp)
         begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   initial
   begin
      rows[0] = {8'h20, 17'h11234};
      rows[1] = {8'h3F, 17'h1ABCD};
      rows[2] = {8'h40, 17'h00000};
      rows[3] = {8'hA0, 17'h00000};
      repeat (4) @(posedge clk_sys);
      #5 rst_n = 1'b1;
      u_host_mcu.step(4'h8, 16'h0000);
      u_host_mcu.step(4'h1, 16'h5A5A);
      u_host_mcu.step(4'h8, 16'h001F);
      u_host_mcu.step(4'h1, 16'hC3C3);
      check({1'b0, wa}, 17'h00000);
      u_host_mcu.step(4'h2, 16'h0000);
      check({1'b0, wa}, 17'h05A5A);
      check({1'b0, wb}, 17'h0C3C3);
      u_host_mcu.step(4'h3, 16'h0000);
      repeat (2) @(posedge clk_sys);
      #5 ua = 16'h0F0F;
      $display("wire input test done");
      for (i = 0; i < 4; i = i + 1)
      begin
         u_host_mcu.step(4'h8, {8'h00, rows[i][24:17]});
         u_host_mcu.step(4'h4, 16'h0000);
         check({hout[0], dout}, rows[i][16:0]);
         check({16'h0000, hout[1]}, 17'h00001);
         $display("read test %0d done", i);
      end
      rst_n = 1'b0;
      #20 check({hout[0], wa}, 17'h00000);
      $display("reset test done");
      conclude;
   end
   initial
   begin
      #100000;
      fail_count = fail_count + 1;
      conclude;
   end
endmodule // host_endpoint_bus_wires_tb
bind host_gateway host_gateway_asserts u_host_gateway_asserts (.clk_sys(clk_sys),
   .rst_n(rst_n), .host_pin_inputs(host_pin_inputs), .host_pin_outputs(host_pin_outputs),
   .host_pin_bidir_data_oe(host_pin_bidir_data_oe), .target_bus_clock(target_bus_clock),
   .target_ctrl_down(target_ctrl_down));
